// *** apdu_regs.svh ***
// Constants of the command length checker and status coder
`ifndef APDU_REGS_SVH
`define APDU_REGS_SVH

// ----------------------------------------------------------------
// Command framing
// ----------------------------------------------------------------
`define APDU_HDR_BYTES 4
`define APDU_LC_MIN 1
`define APDU_LC_MAX 255
`define APDU_LE_MAX 256
`define APDU_LC_POS 4
`define APDU_DATA_POS 5

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define APDU_BUF_DEPTH 256
`define APDU_CNT_W 9
`define APDU_SW_RESET 16'h0000

`endif

// *** apdu_pkg.sv ***
// Types shared by the command length checker and status coder
package apdu_pkg;

	// ----------------------------------------------------------------
	// Status words; families with a variable low byte carry 00
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		SW_NORMAL = 16'h9000,
		SW_PROACTIVE = 16'h9100,
		SW_TK_BUSY = 16'h9300,
		SW_WARN_NOINFO = 16'h6200,
		SW_WARN_CORRUPT = 16'h6281,
		SW_WARN_EOF = 16'h6282,
		SW_WARN_INVAL = 16'h6283,
		SW_WARN_TERM = 16'h6285,
		SW_MORE_AVAIL = 16'h62f1,
		SW_MORE_AVAIL_PRO = 16'h62f2,
		SW_AUTH_AVAIL = 16'h62f3,
		SW_MORE_EXP = 16'h63f1,
		SW_MORE_EXP_PRO = 16'h63f2,
		SW_RETRY_CNT = 16'h63c0,
		SW_EXE_UNCHANGED = 16'h6400,
		SW_EXE_CHANGED = 16'h6500,
		SW_EXE_MEMORY = 16'h6581,
		SW_WRONG_LEN = 16'h6700,
		SW_WRONG_P1P2 = 16'h6b00,
		SW_BAD_INS = 16'h6d00,
		SW_BAD_CLASS = 16'h6e00,
		SW_TECH = 16'h6f00,
		SW_CLA_NOINFO = 16'h6800,
		SW_CLA_CHANNEL = 16'h6881,
		SW_CLA_SECURE = 16'h6882,
		SW_NA_NOINFO = 16'h6900,
		SW_NA_STRUCT = 16'h6981,
		SW_NA_SECURITY = 16'h6982,
		SW_NA_BLOCKED = 16'h6983,
		SW_NA_INVALID = 16'h6984,
		SW_NA_CONDITIONS = 16'h6985,
		SW_NA_NO_EF = 16'h6986,
		SW_PAR_DATA = 16'h6a80,
		SW_PAR_FUNC = 16'h6a81,
		SW_PAR_FILE = 16'h6a82,
		SW_PAR_RECORD = 16'h6a83,
		SW_PAR_MEMORY = 16'h6a84,
		SW_PAR_P1P2 = 16'h6a86,
		SW_PAR_LC = 16'h6a87,
		SW_PAR_REF = 16'h6a88,
		SW_APP_MAX = 16'h9850,
		SW_APP_AUTH = 16'h9862,
		SW_APP_OWN = 16'h9800
	} sw_code_t;

	// Command forms after the four header bytes
	typedef enum {FORM_NONE, FORM_LE, FORM_LC, FORM_LC_LE} apdu_form_t;

	typedef enum {S_HDR, S_CHECK, S_EXEC, S_PRIME, S_DATA, S_SW1, S_SW2}
		coder_state_t;

	typedef struct packed {
		logic [7:0] cla;
		logic [7:0] ins;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [1:0] form;
		logic [7:0] lc;
		logic le_present;
		logic [8:0] le_max;
	} apdu_hdr_t;

	typedef struct packed {
		sw_code_t code;
		logic [7:0] arg;
		logic [8:0] resp_len;
	} apdu_status_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} byte_beat_t;

endpackage

// *** apdu_buffer.sv ***
// Byte buffer for command data and response data
`timescale 1ns/1ps
module apdu_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 256,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("apdu_buffer: unusable size");
	end

	// Registered read, one cycle behind the address
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule // apdu_buffer

// *** sw_encoder.sv ***
// Turns a status code and its argument into the SW1/SW2 pair
`timescale 1ns/1ps
module sw_encoder
	import apdu_pkg::*;
(
	input sw_code_t i_code,
	input wire logic [7:0] i_arg,
	output logic [15:0] o_word
);
	// Families whose low byte, or for 63 Cx the low nibble, is filled from the argument
	always_comb begin
		case (i_code)
			SW_PROACTIVE: o_word = {i_code[15:8], i_arg};
			SW_RETRY_CNT: o_word = {i_code[15:4], i_arg[3:0]};
			SW_WRONG_LEN: o_word = {i_code[15:8], i_arg};
			SW_TECH: o_word = {i_code[15:8], i_arg};
			SW_APP_OWN: o_word = {i_code[15:8], i_arg};
			default: o_word = i_code;
		endcase
	end
endmodule // sw_encoder

// *** apdu_length_and_status_coder.sv ***
// Command length checker, response framer and status word coder
// Behaviour
// - With Lc present, data field holds exactly Lc bytes, from 1 to 255.
// - Le absent means no response data; present, response carries up to Le bytes.
// - Le of zero asks for up to 256 bytes; return 1 to 256.
// - Response is optional data, then SW1, then SW2, one byte each.
// - Normal end is 90 00; pending proactive command gives 91 and length.
// - Busy toolkit gives 93 00; later normal commands still allowed.
// - Warning 62 with SW2 00, 81, 82, 83 or 85.
// - Warning 62 with F1, F2 or F3 for available data.
// - Warning 63 with F1 or F2 for more data expected.
// - 63 Cx carries a retry count in the low nibble.
// - Execution errors 64 00, 65 00, 65 81.
// - Checking errors 67 00, 6B 00, 6D 00, 6E 00.
// - Technical problem 6F 00; 67 or 6F with nonzero SW2 command-specific.
// - Class function errors 68 with 00, 81 or 82.
// - Command not allowed 69 with 00, 81 to 86.
// - Wrong parameters 6A with 80 to 84, 86, 87, 88.
// - Application errors 98 50, 98 62, plus application-defined codes.
// - Four command forms: none, Le, Lc and data, Lc data and Le.
`timescale 1ns/1ps
`include "apdu_regs.svh"
module apdu_length_and_status_coder
	import apdu_pkg::*;
#(
	parameter int BUF_DEPTH = `APDU_BUF_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_cmd_valid,
	input byte_beat_t i_cmd,
	output logic o_cmd_ready,
	output apdu_hdr_t o_hdr,
	output logic o_hdr_valid,
	input wire logic [$clog2(BUF_DEPTH)-1:0] i_app_addr,
	input wire logic i_app_we,
	input wire logic [7:0] i_app_wdata,
	output logic [7:0] o_app_rdata,
	input wire logic i_done,
	input apdu_status_t i_status,
	output logic o_rsp_valid,
	output byte_beat_t o_rsp,
	input wire logic i_rsp_ready
);
	localparam int AW = $clog2(BUF_DEPTH);
	localparam int CW = `APDU_CNT_W;

	// The buffer must hold the largest response that Le allows
	if (BUF_DEPTH < `APDU_LE_MAX) begin : g_bad_depth
		$error("apdu coder: buffer shallower than largest response");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rstn;

	// Assert at once, release after two edges to avoid metastable exit
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rstn = rst_sync[1];

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	coder_state_t state;
	coder_state_t next_state;
	logic [CW-1:0] cnt;
	logic [CW-1:0] n_after;
	logic [CW-1:0] idx;
	logic [CW-1:0] lr;
	logic [CW-1:0] next_lr;
	logic [CW-1:0] le_eff;
	logic [7:0] hdr_byte [`APDU_HDR_BYTES];
	logic [7:0] lc_byte;
	logic [7:0] last_byte;
	logic cmd_fire;
	logic rsp_fire;
	logic len_bad;
	apdu_form_t form;
	logic le_present;
	logic [7:0] le_raw;
	logic [15:0] sw_word;
	logic [15:0] enc_word;
	sw_code_t enc_code;
	logic [7:0] enc_arg;
	logic buf_we;
	logic [AW-1:0] buf_waddr;
	logic [7:0] buf_wdata;
	logic [AW-1:0] buf_raddr;
	logic [7:0] buf_rdata;

	assign cmd_fire = i_cmd_valid && o_cmd_ready;
	assign rsp_fire = o_rsp_valid && i_rsp_ready;
	assign o_cmd_ready = (state == S_HDR);

	// ----------------------------------------------------------------
	// Command capture
	// ----------------------------------------------------------------
	// Counter saturates so an overlong command still reads as wrong length
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (state == S_SW2 && rsp_fire) begin
			cnt <= '0;
		end else if (cmd_fire && cnt != '1) begin
			cnt <= cnt + CW'(1);
		end
	end

	// Header bytes, the byte after them, and the final byte of the frame
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < `APDU_HDR_BYTES; k++) begin
				hdr_byte[k] <= 8'h00;
			end
			lc_byte <= 8'h00;
			last_byte <= 8'h00;
		end else if (cmd_fire) begin
			if (cnt < CW'(`APDU_HDR_BYTES)) begin
				hdr_byte[cnt[1:0]] <= i_cmd.data;
			end
			if (cnt == CW'(`APDU_LC_POS)) begin
				lc_byte <= i_cmd.data;
			end
			last_byte <= i_cmd.data;
		end
	end

	// ----------------------------------------------------------------
	// Form and length check
	// ----------------------------------------------------------------
	// Only the total count tells the forms apart, so decide at frame end
	always_comb begin
		n_after = cnt - CW'(`APDU_HDR_BYTES);
		len_bad = 1'b0;
		form = FORM_NONE;
		le_present = 1'b0;
		le_raw = 8'h00;
		if (cnt < CW'(`APDU_HDR_BYTES)) begin
			len_bad = 1'b1;
		end else if (n_after == '0) begin
			form = FORM_NONE;
		end else if (n_after == CW'(1)) begin
			form = FORM_LE;
			le_present = 1'b1;
			le_raw = lc_byte;
		end else if (lc_byte < 8'(`APDU_LC_MIN)) begin
			len_bad = 1'b1;
		end else if (n_after == CW'(lc_byte) + CW'(1)) begin
			form = FORM_LC;
		end else if (n_after == CW'(lc_byte) + CW'(2)) begin
			form = FORM_LC_LE;
			le_present = 1'b1;
			le_raw = last_byte;
		end else begin
			len_bad = 1'b1;
		end
	end

	// Le of zero widens to the largest response
	assign le_eff = (le_raw == 8'h00) ? CW'(`APDU_LE_MAX) : CW'(le_raw);

	// Decoded header is flagged valid to the application only for a well-formed command
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			o_hdr <= '0;
			o_hdr_valid <= 1'b0;
		end else begin
			o_hdr_valid <= (state == S_CHECK) && !len_bad;
			if (state == S_CHECK) begin
				o_hdr.cla <= hdr_byte[0];
				o_hdr.ins <= hdr_byte[1];
				o_hdr.p1 <= hdr_byte[2];
				o_hdr.p2 <= hdr_byte[3];
				o_hdr.form <= 2'(form);
				o_hdr.lc <= (form == FORM_LC || form == FORM_LC_LE) ?
					lc_byte : 8'h00;
				o_hdr.le_present <= le_present;
				o_hdr.le_max <= le_present ? le_eff : '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status coding and response length
	// ----------------------------------------------------------------
	// A length fault bypasses the application with a fixed wrong length
	assign enc_code = (state == S_CHECK) ? SW_WRONG_LEN : i_status.code;
	assign enc_arg = (state == S_CHECK) ? 8'h00 : i_status.arg;

	sw_encoder u_enc (
		.i_code(enc_code),
		.i_arg(enc_arg),
		.o_word(enc_word)
	);

	// Response data is clipped to what Le allows, none without Le
	always_comb begin
		next_lr = '0;
		if (o_hdr.le_present) begin
			next_lr = (i_status.resp_len > o_hdr.le_max) ?
				o_hdr.le_max : i_status.resp_len;
		end
	end

	// Status word and response length held for the whole response
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			sw_word <= `APDU_SW_RESET;
			lr <= '0;
		end else if (state == S_CHECK && len_bad) begin
			sw_word <= enc_word;
			lr <= '0;
		end else if (state == S_EXEC && i_done) begin
			sw_word <= enc_word;
			lr <= next_lr;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			S_HDR: begin
				if (cmd_fire && i_cmd.last) begin
					next_state = S_CHECK;
				end
			end
			S_CHECK: begin
				next_state = len_bad ? S_SW1 : S_EXEC;
			end
			S_EXEC: begin
				if (i_done) begin
					next_state = (next_lr != '0) ? S_PRIME : S_SW1;
				end
			end
			S_PRIME: begin
				next_state = S_DATA;
			end
			S_DATA: begin
				if (rsp_fire && idx == lr - CW'(1)) begin
					next_state = S_SW1;
				end
			end
			S_SW1: begin
				if (rsp_fire) begin
					next_state = S_SW2;
				end
			end
			S_SW2: begin
				if (rsp_fire) begin
					next_state = S_HDR;
				end
			end
			default: begin
				next_state = S_HDR;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			state <= S_HDR;
		end else begin
			state <= next_state;
		end
	end

	// Index of the response data byte on the port
	// Cleared while executing so the prime read already fetches byte 0
	always_ff @(posedge i_clk or negedge rstn) begin
		if (!rstn) begin
			idx <= '0;
		end else if (state == S_EXEC) begin
			idx <= '0;
		end else if (state == S_DATA && rsp_fire) begin
			idx <= idx + CW'(1);
		end
	end

	// ----------------------------------------------------------------
	// Buffer sharing
	// ----------------------------------------------------------------
	// Command data fills the buffer first; the application then owns it
	always_comb begin
		buf_we = 1'b0;
		buf_waddr = AW'(cnt - CW'(`APDU_DATA_POS));
		buf_wdata = i_cmd.data;
		if (state == S_EXEC) begin
			buf_we = i_app_we;
			buf_waddr = i_app_addr;
			buf_wdata = i_app_wdata;
		end else if (cmd_fire && cnt >= CW'(`APDU_DATA_POS)) begin
			buf_we = (int'(cnt) < `APDU_DATA_POS + BUF_DEPTH);
		end
	end

	// Read one ahead on a taken byte so data streams without gaps
	always_comb begin
		if (state == S_EXEC) begin
			buf_raddr = i_app_addr;
		end else if (state == S_DATA && rsp_fire) begin
			buf_raddr = AW'(idx + CW'(1));
		end else begin
			buf_raddr = AW'(idx);
		end
	end

	apdu_buffer #(
		.WIDTH(8),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.i_clk(i_clk),
		.i_we(buf_we),
		.i_waddr(buf_waddr),
		.i_wdata(buf_wdata),
		.i_raddr(buf_raddr),
		.o_rdata(buf_rdata)
	);
	assign o_app_rdata = buf_rdata;

	// ----------------------------------------------------------------
	// Response port
	// ----------------------------------------------------------------
	// Data bytes first, then the two status bytes, last flag on SW2
	assign o_rsp_valid = (state == S_DATA) || (state == S_SW1) ||
		(state == S_SW2);
	always_comb begin
		o_rsp.last = (state == S_SW2);
		case (state)
			S_DATA: o_rsp.data = buf_rdata;
			S_SW1: o_rsp.data = sw_word[15:8];
			default: o_rsp.data = sw_word[7:0];
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rstn);

	chk_lc_nonzero: assert property (
		o_hdr_valid && (o_hdr.form == 2'(FORM_LC) ||
			o_hdr.form == 2'(FORM_LC_LE)) |-> o_hdr.lc != 8'h00)
		else $error("Lc of zero accepted");

	chk_no_le_data: assert property (
		state == S_EXEC && i_done && !o_hdr.le_present |=>
			state == S_SW1)
		else $error("Response data sent without Le");

	chk_le_bound: assert property (
		state == S_DATA |-> lr >= CW'(1) && lr <= o_hdr.le_max)
		else $error("Response length outside Le");

	chk_sw_order: assert property (
		state == S_SW1 && rsp_fire |=>
			o_rsp_valid && o_rsp.last && o_rsp.data == $past(sw_word[7:0]))
		else $error("SW2 does not follow SW1");

	chk_proactive_len: assert property (
		state == S_EXEC && i_done && i_status.code == SW_PROACTIVE |=>
			sw_word == {8'h91, $past(i_status.arg)})
		else $error("Proactive status length wrong");

	chk_retry_nibble: assert property (
		enc_code == SW_RETRY_CNT |-> enc_word[15:4] == 12'h63c &&
			enc_word[3:0] == enc_arg[3:0])
		else $error("Retry count not in low nibble");

	chk_wrong_len: assert property (
		state == S_CHECK && len_bad |=> state == S_SW1 &&
			sw_word == 16'h6700 && !o_hdr_valid)
		else $error("Length fault not reported as wrong length");

	chk_busy_return: assert property (
		state == S_SW2 && rsp_fire |=> o_cmd_ready)
		else $error("Card not ready for next command");

	chk_data_count: assert property (
		state == S_DATA && rsp_fire && idx == lr - CW'(1) |=>
			state == S_SW1 ##0 o_rsp.data == sw_word[15:8])
		else $error("SW1 not after last data byte");
endmodule // apdu_length_and_status_coder

// *** apdu_terminal_model.sv ***
// Terminal-side model: sends command bytes and takes response bytes
`timescale 1ns/1ps
module apdu_terminal_model
	import apdu_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_cmd_ready,
	input wire logic i_rsp_valid,
	input byte_beat_t i_rsp,
	output logic o_cmd_valid,
	output byte_beat_t o_cmd,
	output logic o_rsp_ready
);
	logic [7:0] rx[$];
	int last_idx;
	bit stall;
	int phase;

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
		o_rsp_ready = 1'b0;
		stall = 1'b0;
		phase = 0;
		last_idx = -1;
	end

	// ----------------------------------------------------------------
	// Response side
	// ----------------------------------------------------------------
	// Stalling drops ready two cycles in three, to test byte holding
	always @(posedge i_clk) begin
		if (i_rsp_valid && o_rsp_ready) begin
			rx.push_back(i_rsp.data);
			if (i_rsp.last)
				last_idx = rx.size() - 1;
		end
		phase <= (phase + 1) % 3;
		o_rsp_ready <= !stall || (phase == 0);
	end

	// Pattern of command data byte k
	function automatic logic [7:0] data_at(input int k);
		return k[7:0] ^ 8'h3c;
	endfunction

	// ----------------------------------------------------------------
	// Command side
	// ----------------------------------------------------------------
	// Byte held until taken; released line shows the inverse, not stale
	task automatic send(input logic [7:0] q[$]);
		foreach (q[k]) begin
			o_cmd_valid <= 1'b1;
			o_cmd <= '{data: q[k], last: (k == q.size() - 1)};
			@(posedge i_clk);
			while (!i_cmd_ready)
				@(posedge i_clk);
		end
		o_cmd_valid <= 1'b0;
		o_cmd <= '{data: ~q[q.size() - 1], last: 1'b0};
	endtask

	// Builds a command; drop removes data bytes on purpose
	task automatic command(input int lc, input bit has_le,
		input logic [7:0] le, input int drop);
		logic [7:0] q[$];
		q = '{8'h80, 8'ha5, 8'h00, 8'h00}; // Unused P1 P2 zero
		if (lc > 0)
			q.push_back(lc[7:0]);
		for (int k = 0; k < lc - drop; k++)
			q.push_back(data_at(k)); // Lc bytes minus drop
		if (has_le)
			q.push_back(le); // Le only when data wanted
		send(q);
	endtask
endmodule // apdu_terminal_model

// *** apdu_length_and_status_coder_bench.sv ***
// Self-checking bench of the length checker and status coder
`timescale 1ns/1ps
module apdu_length_and_status_coder_bench;
	import apdu_pkg::*;
	logic i_clk, i_resetn, i_cmd_valid, o_cmd_ready, o_hdr_valid;
	logic i_app_we, i_done, o_rsp_valid, i_rsp_ready;
	logic [7:0] i_app_addr, i_app_wdata, o_app_rdata;
	byte_beat_t i_cmd, o_rsp;
	apdu_hdr_t o_hdr;
	apdu_status_t i_status;
	int errors, n_compared, cycles;
	bit seen;
	logic [7:0] rd;

	apdu_length_and_status_coder #(.BUF_DEPTH(256)) DUT (.i_clk(i_clk),
		.i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
		.o_cmd_ready(o_cmd_ready), .o_hdr(o_hdr), .o_hdr_valid(o_hdr_valid),
		.i_app_addr(i_app_addr), .i_app_we(i_app_we),
		.i_app_wdata(i_app_wdata), .o_app_rdata(o_app_rdata),
		.i_done(i_done), .i_status(i_status), .o_rsp_valid(o_rsp_valid),
		.o_rsp(o_rsp), .i_rsp_ready(i_rsp_ready));

	apdu_terminal_model term (.i_clk(i_clk), .i_cmd_ready(o_cmd_ready),
		.i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp), .o_cmd_valid(i_cmd_valid),
		.o_cmd(i_cmd), .o_rsp_ready(i_rsp_ready));

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// Whole run needs little more than a thousand cycles; ceiling well above that
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("[FAIL] run timeout expected end seen hang");
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Header pulse is due one cycle after the last byte is taken; four allowed
	task automatic wait_hdr(output bit s);
		s = 1'b0;
		repeat (4) begin
			@(posedge i_clk);
			#1;
			if (o_hdr_valid === 1'b1)
				s = 1'b1;
		end
	endtask

	// One cycle of registered latency on the buffer read port
	task automatic read_buf(input int a, output logic [7:0] v);
		@(posedge i_clk);
		i_app_addr <= a[7:0];
		@(posedge i_clk);
		#1;
		v = o_app_rdata;
	endtask

	task automatic finish_cmd(input int nwr, input sw_code_t c,
		input logic [7:0] arg, input int rlen);
		for (int k = 0; k < nwr; k++) begin
			@(posedge i_clk);
			i_app_we <= 1'b1;
			i_app_addr <= k[7:0];
			i_app_wdata <= 8'hc0 + k[7:0];
		end
		@(posedge i_clk);
		i_app_we <= 1'b0;
		i_done <= 1'b1;
		i_status <= '{code: c, arg: arg, resp_len: rlen[8:0]};
		@(posedge i_clk);
		i_done <= 1'b0;
	endtask

	// Data bytes first, then SW1, then SW2 flagged last
	task automatic take_rsp(input int nd, input logic [15:0] sw);
		int t;
		t = 0;
		while (term.rx.size() < nd + 2 && t < 1000) begin
			@(posedge i_clk);
			t++;
		end
		repeat (4) @(posedge i_clk);
		check("response size", 16'(nd + 2), 16'(term.rx.size()));
		if (term.rx.size() == nd + 2) begin
			for (int k = 0; k < nd; k++)
				check("data byte", {8'h00, 8'hc0 + k[7:0]}, {8'h00, term.rx[k]});
			check("status word", sw, {term.rx[nd], term.rx[nd + 1]});
			check("last flag position", 16'(nd + 1), 16'(term.last_idx));
		end
		term.rx.delete();
		term.last_idx = -1;
	endtask

	function automatic logic [15:0] exp_sw(input sw_code_t c,
		input logic [7:0] a);
		case (c)
			SW_PROACTIVE, SW_WRONG_LEN, SW_TECH, SW_APP_OWN: return {c[15:8], a};
			SW_RETRY_CNT: return {8'h63, 4'hc, a[3:0]};
			default: return c;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_no_fields();
		term.command(0, 0, 8'h00, 0);
		wait_hdr(seen);
		check("header pulse", 16'h1, 16'(seen));
		check("form", 16'h0, 16'(o_hdr.form));
		check("le present", 16'h0, 16'(o_hdr.le_present));
		check("cla ins", 16'h80a5, {o_hdr.cla, o_hdr.ins});
		check("p1 p2", 16'h0000, {o_hdr.p1, o_hdr.p2});
		check("cmd ready while executing", 16'h0, 16'(o_cmd_ready));
		finish_cmd(0, SW_NORMAL, 8'h00, 5);
		take_rsp(0, 16'h9000); // No Le, no data returned
		$display("test no_fields done");
	endtask

	task automatic t_le_only();
		term.stall = 1'b1;
		term.command(0, 1, 8'h02, 0);
		wait_hdr(seen);
		check("form", 16'h1, 16'(o_hdr.form));
		check("le max", 16'h2, 16'(o_hdr.le_max));
		finish_cmd(3, SW_NORMAL, 8'h00, 3);
		take_rsp(2, 16'h9000); // Trimmed to Le
		term.command(0, 1, 8'h00, 0);
		wait_hdr(seen);
		check("le max", 16'd256, 16'(o_hdr.le_max));
		finish_cmd(3, SW_PROACTIVE, 8'h1d, 3);
		take_rsp(3, 16'h911d);
		term.stall = 1'b0;
		$display("test le_only done");
	endtask

	task automatic t_lc_forms();
		term.command(255, 0, 8'h00, 0);
		wait_hdr(seen);
		check("header pulse", 16'h1, 16'(seen));
		check("form", 16'h2, 16'(o_hdr.form));
		check("lc", 16'd255, 16'(o_hdr.lc));
		read_buf(254, rd);
		check("data 254", 16'(term.data_at(254)), 16'(rd));
		finish_cmd(0, SW_NORMAL, 8'h00, 0);
		take_rsp(0, 16'h9000);
		term.command(1, 1, 8'h01, 0);
		wait_hdr(seen);
		check("form", 16'h3, 16'(o_hdr.form));
		check("lc", 16'h1, 16'(o_hdr.lc));
		read_buf(0, rd);
		check("data 0", 16'(term.data_at(0)), 16'(rd));
		finish_cmd(2, SW_NORMAL, 8'h00, 2);
		take_rsp(1, 16'h9000);
		$display("test lc_forms done");
	endtask

	task automatic t_bad_length();
		term.command(3, 0, 8'h00, 1);
		wait_hdr(seen);
		check("no header pulse", 16'h0, 16'(seen));
		take_rsp(0, 16'h6700);
		term.send('{8'h80, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h11});
		wait_hdr(seen);
		check("no header pulse", 16'h0, 16'(seen));
		take_rsp(0, 16'h6700); // Lc of zero refused
		term.send('{8'h80, 8'ha5, 8'h00});
		wait_hdr(seen);
		check("no header pulse", 16'h0, 16'(seen));
		take_rsp(0, 16'h6700);
		$display("test bad_length done");
	endtask

	// Every code in turn, back to back; busy must not block the next
	task automatic t_codes();
		sw_code_t c;
		c = c.first();
		do begin
			term.command(0, 0, 8'h00, 0);
			wait_hdr(seen);
			check("header pulse", 16'h1, 16'(seen));
			finish_cmd(0, c, 8'h5a, 0);
			take_rsp(0, exp_sw(c, 8'h5a));
			c = c.next();
		end while (c != c.first());
		$display("test codes done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_resetn = 1'b0;
		i_app_addr = '0;
		i_app_we = 1'b0;
		i_app_wdata = '0;
		i_done = 1'b0;
		i_status = '0;
		repeat (10) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_no_fields();
		t_le_only();
		t_lc_forms();
		t_bad_length();
		t_codes();
		test_done();
	end
endmodule // apdu_length_and_status_coder_bench
